// [hdl/dsr_pkg.sv]
// Functional notes
// - Eight-bit read/write digitizer delay trim, reset value 0x1f.
// - Bits 6:4 of status show the current loop state code 0..5.
// - Status bit 1 shows the selected reference, 0 first, 1 second.
// - Status bit 0 shows live lock, 1 locked, reset 0.
// - Event bit 3 sets on any loop state change; write 1 clears.
// - Event bit 2 sets on entering holdover; sticky until written 1.
// - Event bit 1 held while unlock count exceeds threshold; clears refused meanwhile.
// - Event bit 0 sets on locked to unlocked; sticky until written 1.
// - Four-bit unlock counter counts lock losses, saturating at 0xf.
// - Software writes the unlock counter to clear or preset it.
// - Alarm threshold is a fixed hardware constant, not configurable.
// - Counter writes are dropped while the loop is gated or in soft reset.
// - Lock after error stays below threshold for timer; acquire done at half.
package dsr_pkg;

  // ==========================================================
  // Register map (byte addresses)
  // ==========================================================
  localparam logic [7:0] OFF_DELAY = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_EVENTS = 8'h08;
  localparam logic [7:0] OFF_LOL_CNT = 8'h0c;
  localparam logic [7:0] OFF_IRQ_EN = 8'h10;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h14;
  localparam logic [7:0] OFF_LOCK_CFG = 8'h18;

  // ==========================================================
  // Reset values and fields
  // ==========================================================
  localparam logic [7:0] RST_DELAY = 8'h1f;
  localparam logic [3:0] RST_EVENTS = 4'h0;
  localparam logic [3:0] RST_LOL_CNT = 4'h0;
  localparam logic [3:0] RST_IRQ_EN = 4'h0;
  localparam logic [15:0] RST_LOCK_TIMER = 16'h00ff;
  localparam logic [15:0] RST_LOCK_THRESH = 16'h0155;
  localparam int STS_LOCK_BIT = 0;
  localparam int STS_REF_BIT = 1;
  localparam int STS_STATE_LSB = 4;
  localparam int EVT_LOL_BIT = 0;
  localparam int EVT_ALARM_BIT = 1;
  localparam int EVT_HOLD_BIT = 2;
  localparam int EVT_STATE_BIT = 3;
  localparam int EVT_WIDTH = 4;
  localparam logic [3:0] LOL_CNT_MAX = 4'hf;
  localparam logic [3:0] LOL_ALARM_THRESH = 4'h8;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int CLK_PERIOD_NS = 10;
  localparam int LOCK_UNIT_NS = 1000000;
  localparam int LOCK_UNIT_CYCLES = LOCK_UNIT_NS / CLK_PERIOD_NS;

  // ==========================================================
  // Bus answers and types
  // ==========================================================
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_FREERUN = 3'h0,
    ST_NORMAL = 3'h1,
    ST_HOLDOVER = 3'h2,
    ST_WRITE_FREQ = 3'h3,
    ST_ACQUIRE = 3'h4,
    ST_HITLESS = 3'h5
  } dsr_loop_state_t;

  typedef struct packed {
    dsr_loop_state_t state;
    logic refSelect;
    logic softReset;
    logic clockGated;
  } dsr_loop_t;

endpackage : dsr_pkg

// [hdl/dsr_lock_qualifier.sv]
`timescale 1ns/1ns
module dsr_lock_qualifier #(
  parameter int UNIT_CYCLES = dsr_pkg::LOCK_UNIT_CYCLES
) (
  input wire logic sys_clk, // System clock
  input wire logic rst_n, // Async reset, active low
  input wire logic softReset, // Loop soft reset
  input wire logic [15:0] phaseErrAbs, // Absolute phase error
  input wire logic [15:0] lockThresh, // Error threshold
  input wire logic [15:0] lockTimer, // Qualify interval in ms
  output logic acquireDone, // Half interval met
  output logic locked // Full interval met
);

  // ==========================================================
  // Millisecond prescaler and qualify timer
  // ==========================================================
  logic [31:0] tickCnt;
  logic [15:0] msCnt;
  logic errHigh;
  logic tickWrap;

  assign errHigh = phaseErrAbs >= lockThresh;
  assign tickWrap = tickCnt == 32'(UNIT_CYCLES - 1);

  // Any excursion restarts the whole interval
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tickCnt <= 32'h0;
      msCnt <= 16'h0;
    end
    else if (softReset || errHigh)
    begin
      tickCnt <= 32'h0;
      msCnt <= 16'h0;
    end
    else if (tickWrap)
    begin
      tickCnt <= 32'h0;
      if (msCnt != 16'hffff)
        msCnt <= msCnt + 16'h1;
    end
    else
    begin
      tickCnt <= tickCnt + 32'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acquireDone <= 1'b0;
      locked <= 1'b0;
    end
    else
    begin
      acquireDone <= !softReset && !errHigh && msCnt >= (lockTimer >> 1);
      locked <= !softReset && !errHigh && msCnt >= lockTimer;
    end
  end

endmodule : dsr_lock_qualifier

// [hdl/dsr_regs.sv]
// Local design decisions: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module dsr_regs #(
  parameter int ADDR_W = 8,
  parameter int UNIT_CYCLES = dsr_pkg::LOCK_UNIT_CYCLES
) (
  input wire logic sys_clk, // System clock, 100 MHz
  input wire logic rst_n, // Async reset, active low
  // AXI4-Lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  // Loop block
  input wire dsr_pkg::dsr_loop_t loopIn, // Loop state and controls
  input wire logic [15:0] phaseErrAbs, // Absolute phase error
  output logic [7:0] phaseDigitizerDelay, // Delay trim to loop
  output logic acquireDone, // Acquire interval met
  output logic lockLive, // Live lock condition
  output logic irq // Level interrupt
);

  // ==========================================================
  // Write channel capture
  // ==========================================================
  logic awHeld;
  logic wHeld;
  logic [ADDR_W-1:0] awAddr;
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic wrFire;
  logic wrKnown;

  assign s_axi_awready = !awHeld;
  assign s_axi_wready = !wHeld;
  assign wrFire = awHeld && wHeld && !s_axi_bvalid;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      awHeld <= 1'b0;
      awAddr <= '0;
    end
    else if (s_axi_awvalid && !awHeld)
    begin
      awHeld <= 1'b1;
      awAddr <= s_axi_awaddr;
    end
    else if (wrFire)
    begin
      awHeld <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wHeld <= 1'b0;
      wData <= 32'h0;
      wStrb <= 4'h0;
    end
    else if (s_axi_wvalid && !wHeld)
    begin
      wHeld <= 1'b1;
      wData <= s_axi_wdata;
      wStrb <= s_axi_wstrb;
    end
    else if (wrFire)
    begin
      wHeld <= 1'b0;
    end
  end

  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    logic [7:0] o;
    o = 8'(a);
    isMapped = a[ADDR_W-1:0] == ADDR_W'(o) && (o == dsr_pkg::OFF_DELAY
      || o == dsr_pkg::OFF_STATUS || o == dsr_pkg::OFF_EVENTS
      || o == dsr_pkg::OFF_LOL_CNT || o == dsr_pkg::OFF_IRQ_EN
      || o == dsr_pkg::OFF_IRQ_CLR || o == dsr_pkg::OFF_LOCK_CFG);
  endfunction : isMapped

  assign wrKnown = isMapped(awAddr);

  function automatic logic wrHit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    wrHit = a == ADDR_W'(off);
  endfunction : wrHit

  logic hitDelay;
  logic hitEvents;
  logic hitCnt;
  logic hitIrqEn;
  logic hitIrqClr;
  logic hitLockCfg;

  // Only byte lane 0 carries the narrow registers
  assign hitDelay = wrFire && wStrb[0] && wrHit(awAddr, dsr_pkg::OFF_DELAY);
  assign hitEvents = wrFire && wStrb[0] && wrHit(awAddr, dsr_pkg::OFF_EVENTS);
  assign hitCnt = wrFire && wStrb[0] && wrHit(awAddr, dsr_pkg::OFF_LOL_CNT);
  assign hitIrqEn = wrFire && wStrb[0] && wrHit(awAddr, dsr_pkg::OFF_IRQ_EN);
  assign hitIrqClr = wrFire && wStrb[0] && wrHit(awAddr, dsr_pkg::OFF_IRQ_CLR);
  assign hitLockCfg = wrFire && wrHit(awAddr, dsr_pkg::OFF_LOCK_CFG);

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= dsr_pkg::RESP_OKAY;
    end
    else if (wrFire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wrKnown ? dsr_pkg::RESP_OKAY : dsr_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Software registers
  // ==========================================================
  logic [3:0] irqEnable;
  logic [31:0] lockCfg;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      phaseDigitizerDelay <= dsr_pkg::RST_DELAY;
    else if (hitDelay)
      phaseDigitizerDelay <= wData[7:0];
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      irqEnable <= dsr_pkg::RST_IRQ_EN;
    else if (hitIrqEn)
      irqEnable <= wData[3:0];
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      lockCfg <= {dsr_pkg::RST_LOCK_TIMER, dsr_pkg::RST_LOCK_THRESH};
    else if (hitLockCfg)
    begin
      for (int b = 0; b < 4; b++)
        if (wStrb[b])
          lockCfg[b*8 +: 8] <= wData[b*8 +: 8];
    end
  end

  // ==========================================================
  // Lock qualification
  // ==========================================================
  dsr_lock_qualifier #(
    .UNIT_CYCLES(UNIT_CYCLES)
  ) uQualifier (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .softReset(loopIn.softReset),
    .phaseErrAbs(phaseErrAbs),
    .lockThresh(lockCfg[15:0]),
    .lockTimer(lockCfg[31:16]),
    .acquireDone(acquireDone),
    .locked(lockLive)
  );

  // ==========================================================
  // Event detection
  // ==========================================================
  logic lockPrev;
  dsr_pkg::dsr_loop_state_t statePrev;
  logic lockFall;
  logic stateMoved;
  logic holdEntered;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lockPrev <= 1'b0;
      statePrev <= dsr_pkg::ST_FREERUN;
    end
    else
    begin
      lockPrev <= lockLive;
      statePrev <= loopIn.state;
    end
  end

  assign lockFall = lockPrev && !lockLive;
  assign stateMoved = loopIn.state != statePrev;
  assign holdEntered = stateMoved && loopIn.state == dsr_pkg::ST_HOLDOVER;

  // ==========================================================
  // Unlock counter and alarm
  // ==========================================================
  logic [3:0] lolCount;
  logic cntWritable;
  logic alarmCond;

  // Gated or held loop cannot take a preset
  assign cntWritable = !loopIn.clockGated && !loopIn.softReset;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      lolCount <= dsr_pkg::RST_LOL_CNT;
    else if (hitCnt && cntWritable)
      lolCount <= wData[3:0];
    else if (lockFall && lolCount != dsr_pkg::LOL_CNT_MAX)
      lolCount <= lolCount + 4'h1;
  end

  // Threshold is a constant so only a preset can hasten the alarm
  assign alarmCond = lolCount > dsr_pkg::LOL_ALARM_THRESH;

  // ==========================================================
  // Sticky events and interrupt
  // ==========================================================
  logic [3:0] events;
  logic [3:0] evSet;
  logic [3:0] evClr;
  logic [3:0] next_events;

  always_comb
  begin
    evSet = 4'h0;
    evSet[dsr_pkg::EVT_LOL_BIT] = lockFall;
    evSet[dsr_pkg::EVT_ALARM_BIT] = alarmCond;
    evSet[dsr_pkg::EVT_HOLD_BIT] = holdEntered;
    evSet[dsr_pkg::EVT_STATE_BIT] = stateMoved;
    evClr = (hitEvents || hitIrqClr) ? wData[3:0] : 4'h0;
    evClr[dsr_pkg::EVT_ALARM_BIT] = evClr[dsr_pkg::EVT_ALARM_BIT] && !alarmCond;
    next_events = (events & ~evClr) | evSet;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      events <= dsr_pkg::RST_EVENTS;
    else
      events <= next_events;
  end

  assign irq = |(events & irqEnable);

  // ==========================================================
  // Read channel
  // ==========================================================
  logic [31:0] rdMux;
  logic [7:0] statusByte;
  logic rdKnown;

  localparam int STS_STATE_MSB = dsr_pkg::STS_STATE_LSB + 2;

  always_comb
  begin
    statusByte = 8'h0;
    statusByte[STS_STATE_MSB:dsr_pkg::STS_STATE_LSB] = loopIn.state;
    statusByte[dsr_pkg::STS_REF_BIT] = loopIn.refSelect;
    statusByte[dsr_pkg::STS_LOCK_BIT] = lockLive;
  end

  always_comb
  begin
    rdMux = 32'h0;
    rdKnown = 1'b1;
    unique case (8'(s_axi_araddr))
      dsr_pkg::OFF_DELAY: rdMux[7:0] = phaseDigitizerDelay;
      dsr_pkg::OFF_STATUS: rdMux[7:0] = statusByte;
      dsr_pkg::OFF_EVENTS: rdMux[3:0] = events;
      dsr_pkg::OFF_LOL_CNT: rdMux[3:0] = lolCount;
      dsr_pkg::OFF_IRQ_EN: rdMux[3:0] = irqEnable;
      dsr_pkg::OFF_IRQ_CLR: rdMux = 32'h0;
      dsr_pkg::OFF_LOCK_CFG: rdMux = lockCfg;
      default: rdKnown = 1'b0;
    endcase
    if (!isMapped(s_axi_araddr))
      rdKnown = 1'b0;
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= dsr_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && !s_axi_rvalid)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdKnown ? rdMux : 32'h0;
      s_axi_rresp <= rdKnown ? dsr_pkg::RESP_OKAY : dsr_pkg::RESP_SLVERR;
    end
    else if (s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : dsr_regs

// [tb/dsr_regs_checker.sv]
`timescale 1ns/1ns
module dsr_regs_checker #(
  parameter int ADDR_W = 8,
  parameter int UNIT_CYCLES = dsr_pkg::LOCK_UNIT_CYCLES
) (
  input wire logic sys_clk, // Clock
  input wire logic rst_n, // Reset
  input wire logic [ADDR_W-1:0] s_axi_araddr, // Read addr
  input wire logic s_axi_arvalid, // Addr valid
  input wire logic s_axi_arready, // Addr ready
  input wire logic [31:0] s_axi_rdata, // Read data
  input wire logic s_axi_rvalid, // Data valid
  input wire logic s_axi_rready, // Data ready
  input wire dsr_pkg::dsr_loop_t loopIn, // Loop inputs
  input wire logic [15:0] phaseErrAbs, // Phase error
  input wire logic [7:0] phaseDigitizerDelay, // Delay trim
  input wire logic acquireDone, // Half interval
  input wire logic lockLive, // Lock
  input wire logic irq // Interrupt
);
  // ========
  // Checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_status_read: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h04 |=>
      s_axi_rdata[6:4] == $past(loopIn.state) && s_axi_rdata[1] == $past(loopIn.refSelect) &&
      s_axi_rdata[0] == $past(lockLive) && {s_axi_rdata[31:7], s_axi_rdata[3:2]} == 27'h0)
    else $error("status read wrong");
  a_delay_read: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h00 |=>
      s_axi_rdata == {24'h0, $past(phaseDigitizerDelay)})
    else $error("delay read wrong");
  a_delay_reset: assert property ($rose(rst_n) |-> phaseDigitizerDelay == 8'h1f)
    else $error("delay reset wrong");
  a_reset_quiet: assert property ($rose(rst_n) |-> !lockLive && !irq)
    else $error("lock or irq after reset");
  a_lock_acq: assert property ($rose(lockLive) |-> acquireDone)
    else $error("lock before acquire");
  a_err_unlock: assert property (phaseErrAbs == 16'hffff [*2] |=> !lockLive)
    else $error("lock with large error");
  a_soft_unlock: assert property (loopIn.softReset [*2] |=> !lockLive)
    else $error("lock in soft reset");
endmodule : dsr_regs_checker

bind dsr_regs dsr_regs_checker #(.ADDR_W(ADDR_W), .UNIT_CYCLES(UNIT_CYCLES)) i_dsr_regs_checker (
  .sys_clk, .rst_n, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .loopIn, .phaseErrAbs, .phaseDigitizerDelay,
  .acquireDone, .lockLive, .irq
);

// [tb/tb.sv]
`timescale 1ns/1ns
module tb;
  logic sys_clk, rst_n, awV, awR, wV, wR, bV, bRdy, arV, arR, rV, rRdy, acq, lock, irq;
  logic [7:0] awA, arA, dly;
  logic [31:0] wD, rD, rdv;
  logic [3:0] wS;
  logic [1:0] bRs, rRs, rrs, wrs;
  logic [15:0] err;
  dsr_pkg::dsr_loop_t loop;
  int n_fail, compares, cyc, i, s;

  // Short lock unit keeps each relock at a few cycles
  dsr_regs #(.UNIT_CYCLES(4)) i_dsr_regs (
    .sys_clk(sys_clk), .rst_n(rst_n), .s_axi_awaddr(awA), .s_axi_awvalid(awV),
    .s_axi_awready(awR), .s_axi_wdata(wD), .s_axi_wstrb(wS), .s_axi_wvalid(wV),
    .s_axi_wready(wR), .s_axi_bresp(bRs), .s_axi_bvalid(bV), .s_axi_bready(bRdy),
    .s_axi_araddr(arA), .s_axi_arvalid(arV), .s_axi_arready(arR), .s_axi_rdata(rD),
    .s_axi_rresp(rRs), .s_axi_rvalid(rV), .s_axi_rready(rRdy), .loopIn(loop),
    .phaseErrAbs(err), .phaseDigitizerDelay(dly), .acquireDone(acq), .lockLive(lock),
    .irq(irq)
  );

  always #5 sys_clk = ~sys_clk;

  // ========
  // Tasks
  task chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk

  task print_verdict;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : print_verdict

  // Readies are looked at 1 ns after an edge, where they are settled
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, ha = 1'b0, hw = 1'b0;
    @(posedge sys_clk);
    awA <= a;
    wD <= d;
    awV <= 1'b1;
    wV <= 1'b1;
    do
    begin
      #1;
      ta = awV & awR;
      tw = wV & wR;
      @(posedge sys_clk);
      if (ta) awV <= 1'b0;
      if (tw) wV <= 1'b0;
      ha = ha | ta;
      hw = hw | tw;
    end
    while (!(ha && hw));
    do
    begin
      #1;
      ta = bV;
      wrs = bRs;
      @(posedge sys_clk);
    end
    while (!ta);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    logic t;
    @(posedge sys_clk);
    arA <= a;
    arV <= 1'b1;
    do
    begin
      #1;
      t = arR;
      @(posedge sys_clk);
    end
    while (!t);
    arV <= 1'b0;
    do
    begin
      #1;
      t = rV;
      rdv = rD;
      rrs = rRs;
      @(posedge sys_clk);
    end
    while (!t);
  endtask : rd

  task rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(rdv, e);
  endtask : rc

  task lose;
    err <= 16'h0000;
    for (i = 0; i < 40 && lock !== 1'b1; i++) @(posedge sys_clk);
    err <= 16'hffff;
    for (i = 0; i < 40 && lock !== 1'b0; i++) @(posedge sys_clk);
  endtask : lose

  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      print_verdict;
    end
  end

  // ========
  // Tests
  initial
  begin
    sys_clk = 0;
    rst_n = 0;
    {awV, wV, arV} = 3'h0;
    {bRdy, rRdy} = 2'h3;
    {awA, arA, wD} = '0;
    wS = 4'hf;
    loop = '0;
    err = 16'hffff;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    rc(8'h00, 32'h1f);
    rc(8'h04, 32'h0);
    rc(8'h08, 32'h0);
    rc(8'h0c, 32'h0);
    wr(8'h00, 32'hffffff5a);
    rc(8'h00, 32'h5a);
    chk(32'(dly), 32'h5a);
    wr(8'h04, 32'hff);
    rc(8'h04, 32'h0);
    rc(8'h1c, 32'h0);
    chk(32'(rrs), 32'h2);
    $display("test regs done");
    loop.state <= dsr_pkg::ST_HOLDOVER;
    loop.refSelect <= 1'b1;
    rc(8'h04, 32'h22);
    rc(8'h08, 32'hc);
    wr(8'h08, 32'hc);
    rc(8'h08, 32'h0);
    for (s = 0; s < 6; s++)
    begin
      loop.state <= dsr_pkg::dsr_loop_state_t'(s);
      rc(8'h04, 32'(s * 16 + 2));
    end
    wr(8'h08, 32'hf);
    rc(8'h08, 32'h0);
    $display("test state done");
    wr(8'h18, 32'h00010155);
    err <= 16'h0000;
    for (i = 0; i < 40 && lock !== 1'b1; i++) @(posedge sys_clk);
    rc(8'h04, 32'h53);
    chk(32'(acq), 32'h1);
    err <= 16'hffff;
    for (i = 0; i < 40 && lock !== 1'b0; i++) @(posedge sys_clk);
    rc(8'h08, 32'h1);
    rc(8'h0c, 32'h1);
    wr(8'h08, 32'h1);
    $display("test lock done");
    wr(8'h0c, 32'h8);
    rc(8'h0c, 32'h8);
    lose;
    rc(8'h0c, 32'h9);
    rc(8'h08, 32'h3);
    wr(8'h08, 32'h3);
    rc(8'h08, 32'h2);
    wr(8'h10, 32'h2);
    #1;
    chk(32'(irq), 32'h1);
    wr(8'h0c, 32'h0);
    wr(8'h14, 32'h2);
    rc(8'h08, 32'h0);
    chk(32'(irq), 32'h0);
    wr(8'h0c, 32'he);
    lose;
    lose;
    rc(8'h0c, 32'hf);
    wr(8'h10, 32'h1);
    #1;
    chk(32'(irq), 32'h1);
    wr(8'h14, 32'h1);
    rc(8'h08, 32'h2);
    chk(32'(irq), 32'h0);
    $display("test count done");
    loop.softReset <= 1'b1;
    wr(8'h0c, 32'h3);
    rc(8'h0c, 32'hf);
    loop.softReset <= 1'b0;
    loop.clockGated <= 1'b1;
    wr(8'h0c, 32'h3);
    rc(8'h0c, 32'hf);
    loop.clockGated <= 1'b0;
    wr(8'h0c, 32'h0);
    rc(8'h0c, 32'h0);
    wr(8'h20, 32'h1);
    chk(32'(wrs), 32'h2);
    $display("test gate done");
    print_verdict;
  end
endmodule : tb
